// [hdl/dcr_consts.svh]
// constants for the dual clock and reset unit
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH

// ----------------------------------------------------------------
// register map (byte offsets on the 2-bit register port)
// ----------------------------------------------------------------
`define DCR_OFS_CTRL        2'h0
`define DCR_OFS_DIVISOR     2'h1
`define DCR_OFS_STATUS      2'h2

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DCR_CTRL_SCLK_BIT   0
`define DCR_CTRL_POR_BIT    1
`define DCR_ST_MAIN_BIT     0
`define DCR_ST_SLOW_BIT     1
`define DCR_ST_OK_BIT       2
`define DCR_ST_SEL_BIT      3
`define DCR_DIV_RESET       8'hFF
`define DCR_BYTE_ZERO       8'h00

// ----------------------------------------------------------------
// start-up timers and slow clock divider
// ----------------------------------------------------------------
`define DCR_MAIN_PRESET     14'h3FFF
`define DCR_MAIN_ZERO       14'h0000
`define DCR_MAIN_ONE        14'h0001
`define DCR_SLOW_PRESET     6'h3F
`define DCR_SLOW_ZERO       6'h00
`define DCR_SLOW_ONE        6'h01
`define DCR_DIV_ZERO        8'h00
`define DCR_DIV_ONE         8'h01

`endif

// [hdl/dcr_pkg.sv]
// types for the dual clock and reset unit
package dcr_pkg;

    // ----------------------------------------------------------------
    // system reset sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DCR_POR_WAIT,
        DCR_EXT_HOLD,
        DCR_RUNNING
    } dcr_rst_state_t;

endpackage : dcr_pkg

// [hdl/dcr_unit.sv]
// dual clock and reset unit: start-up timers, slow clock source, resets
`timescale 1ns/1ps
`include "dcr_consts.svh"

module dcr_unit
    import dcr_pkg::*;
#(
    parameter logic [13:0] START_PRESET = `DCR_MAIN_PRESET
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       ext_reset_n_pin,
    input  wire logic       stop_main_osc_req,
    input  wire logic       stop_slow_osc_req,
    input  wire logic       slow_osc_pin,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wr_data,
    input  wire logic       reg_wr_stb,
    input  wire logic       reg_rd_stb,
    output logic      [7:0] reg_rd_data,
    output logic            main_osc_en,
    output logic            slow_osc_en,
    output logic            main_clk_good,
    output logic            slow_clk_good,
    output logic            slow_clock_ok_status,
    output logic            slow_clk,
    output logic            slow_src_is_osc,
    output logic            sys_reset_n
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic ext_s1;
    logic ext_s2;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else if (clk_en) begin
            ext_s1 <= ext_reset_n_pin;
            ext_s2 <= ext_s1;
            osc_s1 <= slow_osc_pin;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end

    wire ext_low   = ~ext_s2;
    wire osc_rise  = osc_s2 & ~osc_s3;

    // ----------------------------------------------------------------
    // main oscillator start-up timer
    // ----------------------------------------------------------------
    // one step every second cycle: 3FFF steps span 32766 main cycles
    logic [13:0] main_cnt;
    logic        main_pace;
    wire         main_zero = (main_cnt == `DCR_MAIN_ZERO);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            main_cnt      <= START_PRESET;
            main_pace     <= 1'b0;
            main_osc_en   <= 1'b0;
            main_clk_good <= 1'b0;
        end else if (clk_en) begin
            main_osc_en <= ~stop_main_osc_req;
            if (stop_main_osc_req) begin
                main_cnt      <= START_PRESET;
                main_pace     <= 1'b0;
                main_clk_good <= 1'b0;
            end else begin
                main_pace <= ~main_pace;
                if (main_pace && !main_zero)
                    main_cnt <= main_cnt - `DCR_MAIN_ONE;
                if (main_pace && main_zero)
                    main_clk_good <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // slow oscillator start-up timer, paced by its own edges
    // ----------------------------------------------------------------
    logic [5:0] slow_cnt;
    wire        slow_zero = (slow_cnt == `DCR_SLOW_ZERO);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt      <= `DCR_SLOW_PRESET;
            slow_osc_en   <= 1'b0;
            slow_clk_good <= 1'b0;
        end else if (clk_en) begin
            slow_osc_en <= ~stop_slow_osc_req;
            if (stop_slow_osc_req) begin
                slow_cnt      <= `DCR_SLOW_PRESET;
                slow_clk_good <= 1'b0;
            end else begin
                if (osc_rise && !slow_zero)
                    slow_cnt <= slow_cnt - `DCR_SLOW_ONE;
                slow_clk_good <= slow_zero;
            end
        end
    end

    // ----------------------------------------------------------------
    // power-on and external reset sequencer
    // ----------------------------------------------------------------
    dcr_rst_state_t rst_state;
    dcr_rst_state_t next_rst_state;
    logic [13:0]    por_cnt;
    wire            por_zero = (por_cnt == `DCR_MAIN_ZERO);

    always_comb begin
        next_rst_state = rst_state;
        case (rst_state)
            DCR_POR_WAIT: begin
                if (por_zero)
                    next_rst_state = ext_low ? DCR_EXT_HOLD : DCR_RUNNING;
            end
            DCR_EXT_HOLD: begin
                if (!ext_low)
                    next_rst_state = DCR_RUNNING;
            end
            DCR_RUNNING: begin
                if (ext_low)
                    next_rst_state = DCR_EXT_HOLD;
            end
            default: next_rst_state = DCR_POR_WAIT;
        endcase
    end

    // the count starts only once the core clock runs after power-up
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_state   <= DCR_POR_WAIT;
            por_cnt     <= `DCR_MAIN_PRESET;
            sys_reset_n <= 1'b0;
        end else if (clk_en) begin
            rst_state   <= next_rst_state;
            sys_reset_n <= (next_rst_state == DCR_RUNNING);
            if (rst_state == DCR_POR_WAIT && !por_zero)
                por_cnt <= por_cnt - `DCR_MAIN_ONE;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic       sclk_sel;
    logic       por_flag;
    logic [7:0] divisor;

    wire wr_ctrl = reg_wr_stb && (reg_addr == `DCR_OFS_CTRL);
    wire wr_div  = reg_wr_stb && (reg_addr == `DCR_OFS_DIVISOR);

    // control and divisor return to defaults on any system reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sel <= 1'b0;
            divisor  <= `DCR_DIV_RESET;
        end else if (clk_en) begin
            if (ext_low) begin
                sclk_sel <= 1'b0;
                divisor  <= `DCR_DIV_RESET;
            end else begin
                if (wr_ctrl)
                    sclk_sel <= reg_wr_data[`DCR_CTRL_SCLK_BIT];
                if (wr_div)
                    divisor <= reg_wr_data;
            end
        end
    end

    // only a true power-up sets the flag; external resets leave it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            por_flag <= 1'b1;
        else if (clk_en && wr_ctrl && !reg_wr_data[`DCR_CTRL_POR_BIT])
            por_flag <= 1'b0;
    end

    // ----------------------------------------------------------------
    // slow clock source and divider
    // ----------------------------------------------------------------
    logic       sel_eff;
    logic [7:0] div_cnt;
    logic       div_clk;
    wire        div_wrap = (div_cnt >= divisor);

    // divisor is software's to keep at or under 100 kHz output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_eff              <= 1'b0;
            div_cnt              <= `DCR_DIV_ZERO;
            div_clk              <= 1'b0;
            slow_clk             <= 1'b0;
            slow_src_is_osc      <= 1'b0;
            slow_clock_ok_status <= 1'b0;
        end else if (clk_en) begin
            sel_eff         <= sclk_sel & slow_clk_good;
            slow_src_is_osc <= sel_eff;
            if (sel_eff) begin
                div_cnt <= `DCR_DIV_ZERO;
                div_clk <= 1'b0;
            end else if (div_wrap) begin
                div_cnt <= `DCR_DIV_ZERO;
                div_clk <= ~div_clk;
            end else begin
                div_cnt <= div_cnt + `DCR_DIV_ONE;
            end
            slow_clk <= sel_eff ? osc_s2 : div_clk;
            slow_clock_ok_status <= sel_eff ? slow_clk_good : main_clk_good;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    wire [7:0] ctrl_view = {6'h00, por_flag, sclk_sel};
    wire [7:0] stat_view = {4'h0, sel_eff, slow_clock_ok_status,
                            slow_clk_good, main_clk_good};
    wire [7:0] rd_mux    = (reg_addr == `DCR_OFS_CTRL)    ? ctrl_view :
                           (reg_addr == `DCR_OFS_DIVISOR) ? divisor   :
                           (reg_addr == `DCR_OFS_STATUS)  ? stat_view :
                                                            `DCR_BYTE_ZERO;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            reg_rd_data <= `DCR_BYTE_ZERO;
        else if (clk_en)
            reg_rd_data <= reg_rd_stb ? rd_mux : `DCR_BYTE_ZERO;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking dcr_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_main_halt;
        (clk_en && stop_main_osc_req) |=>
            (main_cnt == START_PRESET) && !main_osc_en && !main_clk_good;
    endproperty
    a_main_halt: assert property (p_main_halt)
        else $error("main halt did not preset timer");

    property p_main_good_zero;
        main_clk_good |-> main_zero;
    endproperty
    a_main_good_zero: assert property (p_main_good_zero)
        else $error("main good with nonzero timer");

    property p_main_good_rise;
        $rose(main_clk_good) |->
            $past(main_pace) && $past(main_zero) && !$past(stop_main_osc_req);
    endproperty
    a_main_good_rise: assert property (p_main_good_rise)
        else $error("main good rose off pace");

    property p_slow_halt;
        (clk_en && stop_slow_osc_req) |=>
            (slow_cnt == `DCR_SLOW_PRESET) && !slow_osc_en && !slow_clk_good;
    endproperty
    a_slow_halt: assert property (p_slow_halt)
        else $error("slow halt did not preset timer");

    property p_div_wrap;
        (clk_en && !sel_eff && div_wrap) |=>
            (div_cnt == `DCR_DIV_ZERO) && (div_clk != $past(div_clk));
    endproperty
    a_div_wrap: assert property (p_div_wrap)
        else $error("divider did not wrap and toggle");

    property p_sel_needs_osc;
        sel_eff |-> $past(slow_clk_good) && $past(sclk_sel);
    endproperty
    a_sel_needs_osc: assert property (p_sel_needs_osc)
        else $error("oscillator source taken while not toggling");

    property p_div_off;
        (sel_eff && $past(sel_eff) && $past(clk_en)) |-> (div_cnt == `DCR_DIV_ZERO);
    endproperty
    a_div_off: assert property (p_div_off)
        else $error("divider running on oscillator source");

    property p_por_sticky;
        (clk_en && wr_ctrl && reg_wr_data[`DCR_CTRL_POR_BIT]) |=>
            (por_flag == $past(por_flag));
    endproperty
    a_por_sticky: assert property (p_por_sticky)
        else $error("power-on flag changed by a write of one");

    property p_ext_reset;
        (clk_en && ext_low) |=> !sys_reset_n;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("external reset not applied");

    property p_por_release;
        (clk_en && rst_state == DCR_POR_WAIT && por_zero && !ext_low) |=> sys_reset_n;
    endproperty
    a_por_release: assert property (p_por_release)
        else $error("reset not released at zero count");

    property p_ok_status;
        clk_en |=> slow_clock_ok_status ==
            ($past(sel_eff) ? $past(slow_clk_good) : $past(main_clk_good));
    endproperty
    a_ok_status: assert property (p_ok_status)
        else $error("slow clock status mismatch");

endmodule : dcr_unit

// [tb/dcr_pmu_model.sv]
// power management model driving the oscillator halt requests
`timescale 1ns/1ps

module dcr_pmu_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic halt_main_cmd,
    input  wire logic halt_slow_cmd,
    output logic      stop_main_osc_req,
    output logic      stop_slow_osc_req
);
    // requests move only just after an edge; slow halted out of reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_main_osc_req <= 1'b0;
            stop_slow_osc_req <= 1'b1;
        end else begin
            stop_main_osc_req <= halt_main_cmd;
            stop_slow_osc_req <= halt_slow_cmd;
        end
    end
endmodule : dcr_pmu_model

// [tb/tb_top.sv]
// self-checking bench for the dual clock and reset unit
`timescale 1ns/1ps

module tb_top;
    import dcr_pkg::*;
    typedef struct {logic wr; logic [1:0] addr; logic [7:0] data;} dcr_row_t;
    logic       core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ext_reset_n_pin = 1'b1;
    logic       reg_wr_stb = 1'b0, reg_rd_stb = 1'b0, slow_osc_pin = 1'b0;
    logic       halt_main_cmd = 1'b0, halt_slow_cmd = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wr_data = 8'h00, reg_rd_data, d;
    logic [2:0] osc_div = 3'h0;
    logic       stop_main_osc_req, stop_slow_osc_req, main_osc_en, slow_osc_en;
    logic       main_clk_good, slow_clk_good, slow_clock_ok_status, slow_clk;
    logic       slow_src_is_osc, sys_reset_n;
    int         err_count = 0, check_count = 0, cyc = 0, rises = 0, n, r0, p;
    dcr_row_t   rows[14] = '{'{0, 0, 8'h02}, '{0, 1, 8'hFF}, '{0, 3, 8'h00},
        '{1, 1, 8'h03}, '{0, 1, 8'h03}, '{1, 3, 8'hAA}, '{0, 3, 8'h00},
        '{0, 1, 8'h03}, '{1, 0, 8'hFE}, '{0, 0, 8'h02}, '{1, 0, 8'h00},
        '{0, 0, 8'h00}, '{1, 0, 8'h02}, '{0, 0, 8'h00}};
    logic [7:0] divs[3] = '{8'h00, 8'h03, 8'hFF};

    dcr_unit #(.START_PRESET(14'h0007)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .ext_reset_n_pin(ext_reset_n_pin), .stop_main_osc_req(stop_main_osc_req),
        .stop_slow_osc_req(stop_slow_osc_req), .slow_osc_pin(slow_osc_pin),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb),
        .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .main_osc_en(main_osc_en),
        .slow_osc_en(slow_osc_en), .main_clk_good(main_clk_good),
        .slow_clk_good(slow_clk_good), .slow_clock_ok_status(slow_clock_ok_status),
        .slow_clk(slow_clk), .slow_src_is_osc(slow_src_is_osc), .sys_reset_n(sys_reset_n));
    dcr_pmu_model u_pmu (
        .core_clk(core_clk), .rst_n(rst_n), .halt_main_cmd(halt_main_cmd),
        .halt_slow_cmd(halt_slow_cmd), .stop_main_osc_req(stop_main_osc_req),
        .stop_slow_osc_req(stop_slow_osc_req));

    always #5 core_clk = !core_clk;

    // ----------------------------------------------------------------
    // slow crystal stand-in: still while disabled, 16-cycle period
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        osc_div <= osc_div + 3'h1;
        cyc <= cyc + 1;
        if (!slow_osc_en) slow_osc_pin <= 1'b0;
        else if (osc_div == 3'h7) begin
            slow_osc_pin <= !slow_osc_pin;
            if (!slow_osc_pin) rises <= rises + 1;
        end
        if (cyc == 60000) begin
            err_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wr_data <= v;
        reg_wr_stb <= 1'b1;
        @(posedge core_clk);
        reg_wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd_stb <= 1'b1;
        @(posedge core_clk);
        reg_rd_stb <= 1'b0;
        #1;
        v = reg_rd_data;
    endtask : rd

    task automatic wait_lvl(input logic v);
        while (slow_clk !== v && n < 2000) begin
            tick(1);
            n++;
        end
    endtask : wait_lvl

    task automatic wait_rst(input int lim);
        n = 0;
        while (sys_reset_n !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : wait_rst

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        tick(5);
        chk("reset_low", sys_reset_n, 1'b0);
        @(posedge core_clk);
        rst_n <= 1'b1;
        wait_rst(20000);
        chk("por_time", n >= 16380 && n <= 16390, 1'b1);
        $display("test power_on done");
        // ----------------------------------------------------------------
        // register table
        // ----------------------------------------------------------------
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].data);
            else begin
                rd(rows[i].addr, d);
                chk("reg_read", d, rows[i].data);
            end
        end
        $display("test registers done");
        // clock enable low freezes every flop, register writes included
        @(posedge core_clk);
        clk_en <= 1'b0;
        tick(1);
        p = slow_clk;
        wr(1, 8'h55);
        tick(2);
        chk("frozen_clk", slow_clk, p[0]);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd(1, d);
        chk("frozen_div", d, 8'h03);
        $display("test clock_enable done");
        // divider period 2*(divisor+1), first period after a write skipped
        foreach (divs[i]) begin
            wr(1, divs[i]);
            for (int k = 0; k < 2; k++) begin
                n = 0;
                wait_lvl(1'b0);
                wait_lvl(1'b1);
                p = n;
                wait_lvl(1'b0);
                wait_lvl(1'b1);
            end
            chk("div_period", n - p, 2 * (divs[i] + 1));
        end
        $display("test divider done");
        // ----------------------------------------------------------------
        // main halt and restart, source switch, slow start-up
        // ----------------------------------------------------------------
        @(posedge core_clk);
        halt_main_cmd <= 1'b1;
        tick(4);
        chk("main_halt", {main_osc_en, main_clk_good}, 2'b00);
        @(posedge core_clk);
        halt_main_cmd <= 1'b0;
        n = 0;
        while (main_clk_good !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("main_start", n >= 16 && n <= 19, 1'b1);
        wr(0, 8'h01);
        tick(20);
        chk("no_osc_switch", slow_src_is_osc, 1'b0);
        chk("ok_main", slow_clock_ok_status, 1'b1);
        r0 = rises;
        @(posedge core_clk);
        halt_slow_cmd <= 1'b0;
        n = 0;
        while (slow_clk_good !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk("slow_rises", rises - r0, 63);
        tick(4);
        chk("osc_switch", slow_src_is_osc, 1'b1);
        rd(2, d);
        chk("status", d, 8'h0F);
        @(posedge core_clk);
        halt_main_cmd <= 1'b1;
        tick(4);
        chk("ok_no_main", slow_clock_ok_status, 1'b1);
        @(posedge core_clk);
        halt_slow_cmd <= 1'b1;
        tick(6);
        chk("slow_halt", {slow_osc_en, slow_clk_good, slow_src_is_osc}, 3'b000);
        chk("ok_none", slow_clock_ok_status, 1'b0);
        @(posedge core_clk);
        halt_main_cmd <= 1'b0;
        $display("test clocks done");
        // ----------------------------------------------------------------
        // second power-on, then external reset keeps the flag
        // ----------------------------------------------------------------
        @(posedge core_clk);
        rst_n <= 1'b0;
        tick(5);
        @(posedge core_clk);
        rst_n <= 1'b1;
        wait_rst(20000);
        chk("por_again", sys_reset_n, 1'b1);
        wr(0, 8'h03);
        wr(1, 8'h10);
        @(posedge core_clk);
        ext_reset_n_pin <= 1'b0;
        tick(30);
        chk("ext_hold", sys_reset_n, 1'b0);
        @(posedge core_clk);
        ext_reset_n_pin <= 1'b1;
        wait_rst(50);
        chk("ext_release", sys_reset_n, 1'b1);
        rd(0, d);
        chk("ctrl_after_ext", d, 8'h02);
        rd(1, d);
        chk("div_after_ext", d, 8'hFF);
        $display("test resets done");
        test_done();
    end
endmodule : tb_top
